// ### cte_match.sv
// Per-signal pattern and masked bus pattern matcher
`timescale 1ns/1ps
module cte_match
    import cte_pkg::*;
(
    input wire cte_sample_s cur,
    input wire cte_sample_s prev,
    input wire logic [N_SIG*PAT_W-1:0] pattern,
    input wire logic [BUS_W-1:0] bus_val,
    input wire logic [BUS_W-1:0] bus_care,
    output cte_match_s match
);

    // ----------------------------------------------------------------
    // Single-bit signals
    // ----------------------------------------------------------------
    wire logic [N_SIG-1:0] hit;
    wire logic [N_SIG-1:0] used;
    genvar i;
    generate
        for (i = 0; i < N_SIG; i++) begin : g_sig
            cte_pat_e pat;
            logic c;
            logic p;
            logic h;
            assign pat = cte_pat_e'(pattern[i*PAT_W +: PAT_W]);
            assign c = cur.sig[i];
            assign p = prev.sig[i];
            // Edges compare this sample with the previous cycle's
            always_comb begin
                case (pat)
                    PAT_LOW: h = ~c;
                    PAT_HIGH: h = c;
                    PAT_FALL: h = p & ~c;
                    PAT_RISE: h = ~p & c;
                    PAT_EDGE: h = p ^ c;
                    default: h = 1'b1;
                endcase
            end
            assign hit[i] = h;
            // Unused codes behave as ignored
            assign used[i] = (pat != PAT_IGNORE) && (pat <= PAT_EDGE);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Bus value with don't-care bits
    // ----------------------------------------------------------------
    // One driver for the whole carrier
    assign match = {hit, used, ~|((cur.bus ^ bus_val) & bus_care),
                    |bus_care};

endmodule : cte_match

// ### cte_mon_model.sv
// Behavioural model of the monitored user logic
`timescale 1ns/1ps
module cte_mon_model
    import cte_pkg::*;
(
    output logic [N_SIG-1:0] sig,
    output logic [BUS_W-1:0] bus,
    output logic [BUS_W-1:0] bus_b,
    output logic sq
);
    initial begin
        sig = 8'h00;
        bus = 8'h00;
        bus_b = 8'h00;
        sq = 1'b1;
    end

    // Called just after a rising edge, so values only move on edges
    task automatic put(input logic [7:0] s, input logic [7:0] b,
                       input logic [7:0] bb, input logic q);
        sig <= s;
        bus <= b;
        bus_b <= bb;
        sq <= q;
    endtask : put
endmodule : cte_mon_model

// ### cte_pkg.sv
// Constants, enumerations and carrier types of the capture trigger evaluator
package cte_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int N_SIG = 8;
    localparam int BUS_W = 8;
    localparam int LEAF_N = 2;
    localparam int LEAF_SZ = 4;
    localparam int PAT_W = 3;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_PATTERN = 6'h08;
    localparam logic [5:0] OFS_BUS_VAL = 6'h0c;
    localparam logic [5:0] OFS_BUS_CARE = 6'h10;
    localparam logic [5:0] OFS_GROUP = 6'h14;
    localparam logic [5:0] OFS_ADV = 6'h18;
    localparam logic [5:0] OFS_TRIG_TIME = 6'h1c;
    localparam logic [5:0] OFS_ELAPSED = 6'h20;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_TYPE = 2;
    localparam int CTRL_SQ_DIS = 4;
    localparam int CTRL_REC_DISC = 5;
    localparam int GRP_TOP = 6;
    localparam int ADV_OP = 0;
    localparam int ADV_SEL_REG = 3;
    localparam int ADV_CONST = 8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [N_SIG*PAT_W-1:0] PATTERN_RST = 24'h000000;
    localparam logic [BUS_W-1:0] BUS_VAL_RST = 8'h00;
    localparam logic [BUS_W-1:0] BUS_CARE_RST = 8'h00;
    localparam logic [8:0] GROUP_RST = 9'h1b6;
    localparam logic [11:0] ADV_RST = 12'h002;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PAT_IGNORE, PAT_LOW, PAT_HIGH, PAT_FALL, PAT_RISE, PAT_EDGE
    } cte_pat_e;

    typedef enum logic [2:0] {
        GRP_AND, GRP_OR, GRP_NAND, GRP_NOR, GRP_XOR, GRP_XNOR,
        GRP_TRUE, GRP_FALSE
    } cte_grp_e;

    typedef enum logic [2:0] {
        CMP_LT, CMP_LE, CMP_EQ, CMP_NE, CMP_GT, CMP_GE
    } cte_cmp_e;

    typedef enum logic [1:0] {TT_AND, TT_OR, TT_NEST, TT_ADV} cte_ttype_e;
    typedef enum logic [1:0] {SQ_CONT, SQ_INPUT} cte_sq_e;
    typedef enum logic [1:0] {RUN_IDLE, RUN_ACQ, RUN_DONE} cte_run_e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [N_SIG-1:0] sig;
        logic [BUS_W-1:0] bus;
    } cte_sample_s;

    typedef struct packed {
        logic [N_SIG-1:0] sig_hit;
        logic [N_SIG-1:0] sig_used;
        logic bus_hit;
        logic bus_used;
    } cte_match_s;

    typedef struct packed {
        cte_run_e run;
        cte_ttype_e ttype;
        logic sq_dis;
        logic rec_disc;
        logic [N_SIG*PAT_W-1:0] pattern;
        logic [BUS_W-1:0] bus_val;
        logic [BUS_W-1:0] bus_care;
        logic [8:0] group;
        logic [11:0] adv;
        cte_sample_s prev;
        logic [31:0] elapsed;
        logic [31:0] trig_time;
        logic gap;
        logic store;
        logic discont;
        cte_sample_s sample;
        logic ack;
        logic [31:0] dat;
    } cte_state_s;

endpackage : cte_pkg

// ### cte_properties.sv
// Port-level assertions of the trigger evaluator
`timescale 1ns/1ps
module cte_properties
    import cte_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    input wire logic [N_SIG-1:0] MON_SIG,
    input wire logic [BUS_W-1:0] MON_BUS,
    input wire logic [BUS_W-1:0] MON_BUS_B,
    input wire logic SQ_IN,
    input wire logic CAPTURE_EN,
    input wire cte_sample_s CAPTURE_DATA,
    input wire logic DISCONT,
    input wire logic RUNNING,
    input wire logic TRIGGERED
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_one_ack;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    sequence s_fire;
        RUNNING ##1 TRIGGERED;
    endsequence

    bus_answer_a: assert property (s_req |=> s_one_ack)
        else $error("bus answer late or too long");
    capture_gate_a: assert property (CAPTURE_EN |-> $past(RUNNING))
        else $error("sample stored while not acquiring");
    store_qual_a: assert property (RUNNING && SQ_IN |=> CAPTURE_EN)
        else $error("qualified sample not stored");
    capture_data_a: assert property (CAPTURE_EN |->
        CAPTURE_DATA == $past({MON_SIG, MON_BUS}))
        else $error("stored sample differs from input");
    discont_tag_a: assert property (DISCONT |->
        CAPTURE_EN && !$past(CAPTURE_EN))
        else $error("gap mark without a preceding pause");
    trig_source_a: assert property ($rose(TRIGGERED) |-> $past(RUNNING))
        else $error("trigger without acquisition");
    trig_hold_a: assert property (TRIGGERED &&
        !(WB_CYC_I && WB_STB_I && WB_WE_I) |=> TRIGGERED)
        else $error("trigger state lost without a write");
    trig_stop_a: assert property (s_fire |=> !CAPTURE_EN [*2])
        else $error("capture continued after trigger");
    state_excl_a: assert property (!(RUNNING && TRIGGERED))
        else $error("running and triggered together");
endmodule : cte_properties

bind cte_top cte_properties chk (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
    .WB_DAT_O(WB_DAT_O), .MON_SIG(MON_SIG), .MON_BUS(MON_BUS),
    .MON_BUS_B(MON_BUS_B), .SQ_IN(SQ_IN), .CAPTURE_EN(CAPTURE_EN),
    .CAPTURE_DATA(CAPTURE_DATA), .DISCONT(DISCONT), .RUNNING(RUNNING),
    .TRIGGERED(TRIGGERED)
);

// ### cte_top.sv
// Trigger evaluator and storage qualifier of an embedded logic analyzer
// Summary of operation
// - Each signal: ignore, low, high, fall, rise, either edge
// - Bus compared to value, don't-care bits excluded
// - Basic AND fires when all matches hold
// - Leaf groups evaluate first, results feed parent
// - Constant TRUE group gives one
// - Constant FALSE group gives zero
// - Group function: AND OR NAND NOR XOR XNOR constants
// - Plain AND/OR only on bottom-level groups
// - Stored sample after a pause is tagged
// - Run-time disable bypasses storage qualifier
// - Qualifier type fixed at build time
// - Advanced compare: lt le eq ne gt ge
// - Sample continuously; trigger stops capture and holds
// - Elapsed time from start to trigger kept
// - Trigger evaluated every cycle while acquiring
// - Qualifier never affects the trigger result
`timescale 1ns/1ps
module cte_top
    import cte_pkg::*;
#(
    parameter cte_sq_e SQ_TYPE = SQ_INPUT
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic WB_ACK_O,
    output logic [31:0] WB_DAT_O,
    input wire logic [N_SIG-1:0] MON_SIG,
    input wire logic [BUS_W-1:0] MON_BUS,
    input wire logic [BUS_W-1:0] MON_BUS_B,
    input wire logic SQ_IN,
    output logic CAPTURE_EN,
    output cte_sample_s CAPTURE_DATA,
    output logic DISCONT,
    output logic RUNNING,
    output logic TRIGGERED
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Reduction over the members selected by mask
    function automatic logic grp_eval(
        input logic [2:0] fn,
        input logic [LEAF_SZ-1:0] bits,
        input logic [LEAF_SZ-1:0] mask
    );
        logic a;
        logic o;
        logic x;
        a = &(bits | ~mask);
        o = |(bits & mask);
        x = ^(bits & mask);
        case (cte_grp_e'(fn))
            GRP_AND: grp_eval = a;
            GRP_OR: grp_eval = o;
            GRP_NAND: grp_eval = ~a;
            GRP_NOR: grp_eval = ~o;
            GRP_XOR: grp_eval = x;
            GRP_XNOR: grp_eval = ~x;
            GRP_TRUE: grp_eval = 1'b1;
            default: grp_eval = 1'b0;
        endcase
    endfunction : grp_eval

    function automatic logic compare(
        input logic [2:0] op,
        input logic [BUS_W-1:0] a,
        input logic [BUS_W-1:0] b
    );
        case (cte_cmp_e'(op))
            CMP_LT: compare = a < b;
            CMP_LE: compare = a <= b;
            CMP_EQ: compare = a == b;
            CMP_NE: compare = a != b;
            CMP_GT: compare = a > b;
            CMP_GE: compare = a >= b;
            default: compare = 1'b0;
        endcase
    endfunction : compare

    // Byte-lane write merge
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wr,
        input logic [3:0] sel
    );
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
    endfunction : merge

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cte_state_s s_reg;
    cte_state_s s_next;
    cte_sample_s cur;
    cte_match_s m;
    wire logic [LEAF_N-1:0] leaf;
    logic fire;
    logic store_now;
    logic bus_req;
    logic bus_wr;
    logic [31:0] wv;
    logic [31:0] rd;

    assign cur = {MON_SIG, MON_BUS};

    cte_match u_match (
        .cur(cur),
        .prev(s_reg.prev),
        .pattern(s_reg.pattern),
        .bus_val(s_reg.bus_val),
        .bus_care(s_reg.bus_care),
        .match(m)
    );

    // ----------------------------------------------------------------
    // Trigger condition
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LEAF_N; g++) begin : g_leaf
            // Leaf groups reduce their own signal matches first
            assign leaf[g] = grp_eval(s_reg.group[g*3 +: 3],
                                      m.sig_hit[g*LEAF_SZ +: LEAF_SZ],
                                      m.sig_used[g*LEAF_SZ +: LEAF_SZ]);
        end
    endgenerate

    // Only trigger settings and samples feed this; store_now never does
    always_comb begin
        case (s_reg.ttype)
            TT_AND: fire = (&m.sig_hit) & m.bus_hit;
            TT_OR: fire = |(m.sig_hit & m.sig_used) |
                          (m.bus_hit & m.bus_used);
            TT_NEST: fire = grp_eval(s_reg.group[GRP_TOP +: 3],
                                     {{(LEAF_SZ-LEAF_N){1'b0}}, leaf},
                                     {{(LEAF_SZ-LEAF_N){1'b0}},
                                      {LEAF_N{1'b1}}});
            default: fire = compare(s_reg.adv[ADV_OP +: 3], MON_BUS,
                                    s_reg.adv[ADV_SEL_REG] ?
                                    BUS_W'(s_reg.adv[11:ADV_CONST]) :
                                    MON_BUS_B);
        endcase
    end

    // Qualifier type is fixed; only the disable bit changes at run time
    assign store_now = s_reg.sq_dis || (SQ_TYPE == SQ_CONT) ||
                       SQ_IN;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    assign bus_req = WB_CYC_I & WB_STB_I;
    // A write lands at the edge where the master sees ack high
    assign bus_wr = bus_req & WB_WE_I & s_reg.ack;

    always_comb begin
        rd = 32'h0000_0000;
        if ({WB_ADR_I[5:2], 2'b00} == OFS_CTRL) begin
            rd[CTRL_TYPE +: 2] = s_reg.ttype;
            rd[CTRL_SQ_DIS] = s_reg.sq_dis;
            rd[CTRL_REC_DISC] = s_reg.rec_disc;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_STATUS) begin
            rd[1:0] = s_reg.run;
            rd[2] = s_reg.gap;
            rd[4:3] = SQ_TYPE;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_PATTERN) begin
            rd[N_SIG*PAT_W-1:0] = s_reg.pattern;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_BUS_VAL) begin
            rd[BUS_W-1:0] = s_reg.bus_val;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_BUS_CARE) begin
            rd[BUS_W-1:0] = s_reg.bus_care;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_GROUP) begin
            rd[8:0] = s_reg.group;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_ADV) begin
            rd[11:0] = s_reg.adv;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_TRIG_TIME) begin
            rd = s_reg.trig_time;
        end else if ({WB_ADR_I[5:2], 2'b00} == OFS_ELAPSED) begin
            rd = s_reg.elapsed;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        wv = 32'h0000_0000;
        s_next.store = 1'b0;
        s_next.discont = 1'b0;
        s_next.prev = cur;
        s_next.ack = bus_req & ~s_reg.ack;
        if (bus_req & ~s_reg.ack) begin
            s_next.dat = rd;
        end

        // Acquisition: every cycle is examined, stored or not
        if (s_reg.run == RUN_ACQ) begin
            if (s_reg.elapsed != 32'hffff_ffff) begin
                s_next.elapsed = s_reg.elapsed + 32'h0000_0001;
            end
            if (store_now) begin
                s_next.store = 1'b1;
                s_next.sample = cur;
                s_next.discont = s_reg.rec_disc & s_reg.gap;
                s_next.gap = 1'b0;
            end else begin
                s_next.gap = 1'b1;
            end
            if (fire) begin
                // Trigger sample is kept only if store_now is set, then capture freezes
                s_next.run = RUN_DONE;
                s_next.trig_time = s_reg.elapsed;
            end
        end

        // Software writes; a stop or restart overrides a trigger
        if (bus_wr) begin
            if ({WB_ADR_I[5:2], 2'b00} == OFS_CTRL) begin
                wv = merge({26'h0, s_reg.rec_disc, s_reg.sq_dis,
                            s_reg.ttype, 2'b00}, WB_DAT_I, WB_SEL_I);
                s_next.ttype = cte_ttype_e'(wv[CTRL_TYPE +: 2]);
                s_next.sq_dis = wv[CTRL_SQ_DIS];
                s_next.rec_disc = wv[CTRL_REC_DISC];
                if (wv[CTRL_STOP]) begin
                    s_next.run = RUN_IDLE;
                end else if (wv[CTRL_START]) begin
                    s_next.run = RUN_ACQ;
                    s_next.elapsed = 32'h0000_0000;
                    s_next.gap = 1'b0;
                end
            end else if ({WB_ADR_I[5:2], 2'b00} == OFS_PATTERN) begin
                wv = merge({8'h00, s_reg.pattern}, WB_DAT_I, WB_SEL_I);
                s_next.pattern = wv[N_SIG*PAT_W-1:0];
            end else if ({WB_ADR_I[5:2], 2'b00} == OFS_BUS_VAL) begin
                wv = merge({24'h0, s_reg.bus_val}, WB_DAT_I, WB_SEL_I);
                s_next.bus_val = wv[BUS_W-1:0];
            end else if ({WB_ADR_I[5:2], 2'b00} == OFS_BUS_CARE) begin
                wv = merge({24'h0, s_reg.bus_care}, WB_DAT_I, WB_SEL_I);
                s_next.bus_care = wv[BUS_W-1:0];
            end else if ({WB_ADR_I[5:2], 2'b00} == OFS_GROUP) begin
                wv = merge({23'h0, s_reg.group}, WB_DAT_I, WB_SEL_I);
                s_next.group[GRP_TOP-1:0] = wv[GRP_TOP-1:0];
                // Parent group refuses plain AND/OR and keeps its value
                if (wv[GRP_TOP +: 3] != GRP_AND &&
                    wv[GRP_TOP +: 3] != GRP_OR) begin
                    s_next.group[GRP_TOP +: 3] = wv[GRP_TOP +: 3];
                end
            end else if ({WB_ADR_I[5:2], 2'b00} == OFS_ADV) begin
                wv = merge({20'h0, s_reg.adv}, WB_DAT_I, WB_SEL_I);
                s_next.adv = wv[11:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            s_reg.run <= RUN_IDLE;
            s_reg.ttype <= TT_AND;
            s_reg.sq_dis <= 1'b0;
            s_reg.rec_disc <= 1'b0;
            s_reg.pattern <= PATTERN_RST;
            s_reg.bus_val <= BUS_VAL_RST;
            s_reg.bus_care <= BUS_CARE_RST;
            s_reg.group <= GROUP_RST;
            s_reg.adv <= ADV_RST;
            s_reg.prev <= '0;
            s_reg.elapsed <= 32'h0000_0000;
            s_reg.trig_time <= 32'h0000_0000;
            s_reg.gap <= 1'b0;
            s_reg.store <= 1'b0;
            s_reg.discont <= 1'b0;
            s_reg.sample <= '0;
            s_reg.ack <= 1'b0;
            s_reg.dat <= 32'h0000_0000;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign WB_ACK_O = s_reg.ack;
    assign WB_DAT_O = s_reg.dat;
    assign CAPTURE_EN = s_reg.store;
    assign CAPTURE_DATA = s_reg.sample;
    assign DISCONT = s_reg.discont;
    assign RUNNING = (s_reg.run == RUN_ACQ);
    assign TRIGGERED = (s_reg.run == RUN_DONE);

endmodule : cte_top

// ### cte_top_tb.sv
// Self-checking testbench of the trigger evaluator
`timescale 1ns/1ps
module cte_top_tb;
    import cte_pkg::*;
    logic ref_clk;
    logic reset_n;
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] m_sig;
    logic [7:0] m_bus;
    logic [7:0] m_bus_b;
    logic m_sq;
    logic cap_en;
    cte_sample_s cap_data;
    logic discont;
    logic running;
    logic triggered;
    logic [31:0] rd;
    int miscompares;
    int samples_checked;

    always #2 ref_clk = ~ref_clk;

    cte_top #(.SQ_TYPE(SQ_INPUT)) DUT (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
        .MON_SIG(m_sig), .MON_BUS(m_bus), .MON_BUS_B(m_bus_b),
        .SQ_IN(m_sq), .CAPTURE_EN(cap_en), .CAPTURE_DATA(cap_data),
        .DISCONT(discont), .RUNNING(running), .TRIGGERED(triggered)
    );
    cte_mon_model mon (.sig(m_sig), .bus(m_bus), .bus_b(m_bus_b),
        .sq(m_sq));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb_cycle(input logic w, input logic [5:0] a,
                            input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1);
        chk(n, 2);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb_cycle

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        wb_cycle(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rd_chk

    // Control bits 5:2 as given, with the start bit set
    task automatic arm(input logic [3:0] c);
        wr(OFS_CTRL, {26'h0, c, 2'b01});
    endtask : arm

    // Status also shows the input-port qualifier type in bits 4:3
    task automatic state_is(input logic [1:0] e);
        repeat (3) @(posedge ref_clk);
        rd_chk(OFS_STATUS, {27'h0, 2'b01, 1'b0, e});
    endtask : state_is

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_reset();
        chk({28'h0, running, triggered, cap_en, discont}, 32'h0);
        rd_chk(OFS_PATTERN, 32'h0);
        rd_chk(OFS_BUS_CARE, 32'h0);
        rd_chk(OFS_GROUP, 32'h1b6);
        rd_chk(OFS_ADV, 32'h2);
        state_is(2'd0);
        wr(6'h3c, 32'hffff_ffff);
        rd_chk(6'h3c, 32'h0);
    endtask : s_reset

    // Level codes start on the non-matching value, edges on the old one
    task automatic s_patterns();
        logic [5:0] init;
        init = 6'b101010;
        for (int i = 0; i < 6; i++) begin
            mon.put({5'h0, init[i], 2'h0}, 8'h0, 8'h0, 1'b1);
            wr(OFS_PATTERN, 32'(i) << 6);
            arm(4'h0);
            state_is((i == 0) ? 2'd2 : 2'd1);
            mon.put({5'h0, ~init[i], 2'h0}, 8'h0, 8'h0, 1'b1);
            state_is(2'd2);
        end
    endtask : s_patterns

    task automatic s_bus_and();
        wr(OFS_PATTERN, 32'h2);
        wr(OFS_BUS_VAL, 32'h05);
        wr(OFS_BUS_CARE, 32'h0f);
        mon.put(8'h00, 8'hf5, 8'h0, 1'b1);
        arm(4'h0);
        state_is(2'd1);
        mon.put(8'h01, 8'h04, 8'h0, 1'b1);
        state_is(2'd1);
        mon.put(8'h01, 8'ha5, 8'h0, 1'b1);
        state_is(2'd2);
    endtask : s_bus_and

    task automatic s_or();
        wr(OFS_BUS_CARE, 32'h0);
        wr(OFS_PATTERN, 32'h8002);
        mon.put(8'hae, 8'h0, 8'h0, 1'b1);
        arm(4'h1);
        state_is(2'd1);
        mon.put(8'h7e, 8'h0, 8'h0, 1'b1);
        state_is(2'd1);
        mon.put(8'h00, 8'h0, 8'h0, 1'b1);
        state_is(2'd2);
    endtask : s_or

    // Members 0011 in the low group, the high group forced false
    task automatic s_nested();
        logic [7:0] leaf;
        leaf = 8'h66;
        wr(OFS_PATTERN, 32'h0049_2492);
        mon.put(8'h03, 8'h0, 8'h0, 1'b1);
        for (int f = 0; f < 8; f++) begin
            wr(OFS_GROUP, {23'h0, 3'd4, 3'd7, 3'(f)});
            arm(4'h2);
            state_is(2'd1 + 2'(leaf[f]));
        end
        for (int t = 2; t < 8; t++) begin
            wr(OFS_GROUP, {23'h0, 3'(t), 3'd7, 3'd6});
            arm(4'h2);
            state_is(2'd2 - 2'(t % 2));
        end
        wr(OFS_GROUP, {23'h0, 3'd0, 3'd7, 3'd6});
        rd_chk(OFS_GROUP, 32'h1fe);
        wr(OFS_GROUP, {23'h0, 3'd1, 3'd7, 3'd6});
        rd_chk(OFS_GROUP, 32'h1fe);
    endtask : s_nested

    // Bus 5 against 4, 5 and 6; one bit per compare code
    task automatic s_adv();
        logic [5:0] hit [3];
        hit = '{6'b111000, 6'b100110, 6'b001011};
        for (int k = 0; k < 3; k++) begin
            mon.put(8'h0, 8'h05, 8'(4 + k), 1'b1);
            for (int op = 0; op < 6; op++) begin
                wr(OFS_ADV, 32'(op));
                arm(4'h3);
                state_is(2'd1 + 2'(hit[k][op]));
            end
        end
        wr(OFS_ADV, 32'h50a);
        arm(4'h3);
        state_is(2'd2);
    endtask : s_adv

    task automatic s_store();
        wr(OFS_PATTERN, 32'h2);
        mon.put(8'h00, 8'h11, 8'h0, 1'b1);
        arm(4'h8);
        mon.put(8'h00, 8'h22, 8'h0, 1'b0);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, cap_en}, 32'h0);
        mon.put(8'h00, 8'h33, 8'h0, 1'b1);
        repeat (2) @(posedge ref_clk);
        chk({14'h0, cap_en, discont, cap_data}, 32'h3_0033);
        @(posedge ref_clk);
        chk({30'h0, cap_en, discont}, 32'h2);
        mon.put(8'h01, 8'h0, 8'h0, 1'b0);
        repeat (3) @(posedge ref_clk);
        rd_chk(OFS_STATUS, 32'h0e);
        mon.put(8'h00, 8'h0, 8'h0, 1'b0);
        arm(4'hc);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, cap_en}, 32'h1);
        wr(OFS_CTRL, 32'h20);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, cap_en}, 32'h0);
    endtask : s_store

    // Start takes effect at the ack edge; the bus task adds one edge
    task automatic s_elapsed();
        mon.put(8'h00, 8'h0, 8'h0, 1'b1);
        arm(4'h0);
        repeat (10) @(posedge ref_clk);
        mon.put(8'h01, 8'h0, 8'h0, 1'b1);
        state_is(2'd2);
        rd_chk(OFS_TRIG_TIME, 32'd11);
    endtask : s_elapsed

    task automatic complete_run();
        $display("miscompares %0d samples_checked %0d", miscompares,
                 samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        sel = 4'h0;
        wdat = 32'h0;
        miscompares = 0;
        samples_checked = 0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        s_reset();
        s_patterns();
        s_bus_and();
        s_or();
        s_nested();
        s_adv();
        s_store();
        s_elapsed();
        complete_run();
    end
endmodule : cte_top_tb
